// >>> rtl/gpd_pkg.sv
// Shared constants and types of the port A and port B data register block.
package gpd_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] GPD_PA_UPPER_ADDR = 32'hffff8380;
	localparam logic [31:0] GPD_PA_LOWER_ADDR = 32'hffff8382;
	localparam logic [31:0] GPD_PB_ADDR       = 32'hffff8390;

	// ----------------------------------------------------------------
	// Field widths and reset values
	// ----------------------------------------------------------------
	localparam int unsigned GPD_REG_W        = 16;
	localparam int unsigned GPD_PA_UPPER_W   = 8;
	localparam int unsigned GPD_PA_LOWER_W   = 16;
	localparam int unsigned GPD_PA_W         = 24;
	localparam int unsigned GPD_PB_W         = 10;
	localparam int unsigned GPD_PB_ADDR_PINS = 2;
	localparam logic [15:0] GPD_DATA_RESET   = 16'h0000;
	localparam logic [31:0] GPD_RDATA_RESET  = 32'h00000000;

	// ----------------------------------------------------------------
	// Operating modes and access sizes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GPD_MODE_EXT_NOROM0,
		GPD_MODE_EXT_NOROM1,
		GPD_MODE_EXT_ROM,
		GPD_MODE_SINGLE
	} gpd_mode_t;

	typedef enum logic [1:0] {
		GPD_SIZE_BYTE,
		GPD_SIZE_WORD,
		GPD_SIZE_LONG,
		GPD_SIZE_NONE
	} gpd_size_t;

endpackage : gpd_pkg

// >>> rtl/gpd_acc_if.sv
// Decoded register access passed from the bus decoder to the core.
`timescale 1ns/10ps
`default_nettype none
interface gpd_acc_if;
	logic [15:0] pah_wmask;
	logic [15:0] pal_wmask;
	logic [15:0] pb_wmask;
	logic [15:0] pah_wdata;
	logic [15:0] pal_wdata;
	logic [15:0] pb_wdata;
	logic        rd_pa;
	logic        rd_pb;
	logic [31:0] rd_lanes;

	modport dec
	(
		output pah_wmask, pal_wmask, pb_wmask,
		output pah_wdata, pal_wdata, pb_wdata,
		output rd_pa, rd_pb, rd_lanes
	);
	modport core
	(
		input pah_wmask, pal_wmask, pb_wmask,
		input pah_wdata, pal_wdata, pb_wdata,
		input rd_pa, rd_pb, rd_lanes
	);
endinterface : gpd_acc_if
`default_nettype wire

// >>> rtl/gpd_bus_dec.sv
// Address and byte-lane decoder for the port data registers.
`timescale 1ns/10ps
`default_nettype none
module gpd_bus_dec
(
	input  wire logic [31:0]       i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire gpd_pkg::gpd_size_t i_size,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	gpd_acc_if.dec                 acc
);
	import gpd_pkg::*;

	logic [3:0] be;
	logic       word_pa;
	logic       word_pb;

	// Big-endian lanes: the register at an address with bit 1 clear
	// sits in the upper half of the word.
	function automatic logic [15:0] lane_mask(input logic [31:0] ra,
		input logic [3:0] b);
		lane_mask = ra[1] ? {{8{b[1]}}, {8{b[0]}}} : {{8{b[3]}}, {8{b[2]}}};
	endfunction : lane_mask

	function automatic logic [15:0] lane_data(input logic [31:0] ra,
		input logic [31:0] d);
		lane_data = ra[1] ? d[15:0] : d[31:16];
	endfunction : lane_data

	always_comb
	begin
		unique case (i_size)
			GPD_SIZE_BYTE: be = 4'h8 >> i_addr[1:0];
			GPD_SIZE_WORD: be = i_addr[1] ? 4'h3 : 4'hc;
			GPD_SIZE_LONG: be = 4'hf;
			GPD_SIZE_NONE: be = 4'h0;
		endcase
		word_pa = (i_addr[31:2] == GPD_PA_UPPER_ADDR[31:2]);
		word_pb = (i_addr[31:2] == GPD_PB_ADDR[31:2]);
		acc.pah_wmask = (i_wr && word_pa) ?
			lane_mask(GPD_PA_UPPER_ADDR, be) : 16'h0000;
		acc.pal_wmask = (i_wr && word_pa) ?
			lane_mask(GPD_PA_LOWER_ADDR, be) : 16'h0000;
		acc.pb_wmask  = (i_wr && word_pb) ?
			lane_mask(GPD_PB_ADDR, be) : 16'h0000;
		acc.pah_wdata = lane_data(GPD_PA_UPPER_ADDR, i_wdata);
		acc.pal_wdata = lane_data(GPD_PA_LOWER_ADDR, i_wdata);
		acc.pb_wdata  = lane_data(GPD_PB_ADDR, i_wdata);
		acc.rd_pa     = i_rd && word_pa;
		acc.rd_pb     = i_rd && word_pb;
		acc.rd_lanes  = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	end

endmodule : gpd_bus_dec
`default_nettype wire

// >>> rtl/gpd_port_bits.sv
// One port data register with its per-bit read and pin-drive logic.
`timescale 1ns/10ps
`default_nettype none
module gpd_port_bits
#(
	parameter int unsigned W        = 8,
	parameter bit          HAS_PINS = 1'b1
)
(
	input  wire logic          i_mclk,
	input  wire logic          i_resetn,
	input  wire logic [15:0]   i_wmask,
	input  wire logic [15:0]   i_wdata,
	input  wire logic [W-1:0]  i_pin,
	input  wire logic [W-1:0]  i_dir,
	input  wire logic [W-1:0]  i_func,
	output logic      [W-1:0]  o_rd_value,
	output logic      [W-1:0]  o_pin_out,
	output logic      [W-1:0]  o_pin_oe
);
	import gpd_pkg::*;

	typedef struct packed
	{
		logic [W-1:0] data;
		logic [W-1:0] oe;
	} gpd_bits_st_t;

	gpd_bits_st_t st;
	gpd_bits_st_t next_st;

	always_comb
	begin
		next_st = st;
		// Writes always land in the register, whatever the pin role.
		next_st.data = (st.data & ~i_wmask[W-1:0])
			| (i_wdata[W-1:0] & i_wmask[W-1:0]);
		// Only an ordinary output lets the register reach the pin.
		next_st.oe = HAS_PINS ? (i_dir & ~i_func) : '0;
	end

	// Only the power-on reset clears the register; no other reset reaches it.
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			st.data <= GPD_DATA_RESET[W-1:0];
			st.oe   <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Input bits read the live pin, output bits read the register.
	assign o_rd_value = HAS_PINS ? ((i_dir & st.data) | (~i_dir & i_pin))
		: st.data;
	assign o_pin_out  = st.data;
	assign o_pin_oe   = st.oe;

endmodule : gpd_port_bits
`default_nettype wire

// >>> rtl/gpd_top.sv
// Port A and port B data registers with register port and pin logic.
//
// Functional notes
// - Input direction bits read the live pin.
// - Output direction bits read the stored value.
// - Ordinary output pins drive the last written value.
// - Writes to input bits store, pins untouched.
// - Output-direction other function: store, read stored, no drive.
// - Power-on reset clears all data bits.
// - Other resets and low-power modes keep contents.
// - Upper port A: pins 23-16 in bits 7-0.
// - Upper port A read/write even without pins.
// - Lower port A: pins 15-0 in bits 15-0.
// - Port B: pins 9-0, bits 15-10 read zero.
// - Port B takes byte, word, long accesses; resets zero.
// - Port B pins 1-0 role follows operating mode.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module gpd_top
#(
	parameter bit PA_UPPER_PINS = 1'b1
)
(
	input  wire logic                       i_mclk,
	input  wire logic                       i_resetn,
	input  wire logic [31:0]                i_addr,
	input  wire logic [31:0]                i_wdata,
	input  wire gpd_pkg::gpd_size_t         i_size,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	output logic      [31:0]                o_rdata,
	input  wire gpd_pkg::gpd_mode_t         i_mode,
	input  wire logic [gpd_pkg::GPD_PA_W-1:0] i_pa_pin,
	input  wire logic [gpd_pkg::GPD_PA_W-1:0] i_pa_dir,
	input  wire logic [gpd_pkg::GPD_PA_W-1:0] i_pa_func,
	output logic      [gpd_pkg::GPD_PA_W-1:0] o_pa_out,
	output logic      [gpd_pkg::GPD_PA_W-1:0] o_pa_oe,
	input  wire logic [gpd_pkg::GPD_PB_W-1:0] i_pb_pin,
	input  wire logic [gpd_pkg::GPD_PB_W-1:0] i_pb_dir,
	input  wire logic [gpd_pkg::GPD_PB_W-1:0] i_pb_func,
	output logic      [gpd_pkg::GPD_PB_W-1:0] o_pb_out,
	output logic      [gpd_pkg::GPD_PB_W-1:0] o_pb_oe
);
	import gpd_pkg::*;

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	gpd_acc_if acc ();

	gpd_bus_dec u_dec
	(
		.i_addr  (i_addr),
		.i_wdata (i_wdata),
		.i_size  (i_size),
		.i_wr    (i_wr),
		.i_rd    (i_rd),
		.acc     (acc.dec)
	);

	// ----------------------------------------------------------------
	// Effective function select of port B
	// ----------------------------------------------------------------
	logic [GPD_PB_W-1:0] pb_func_eff;

	always_comb
	begin
		pb_func_eff = i_pb_func;
		unique case (i_mode)
			GPD_MODE_EXT_NOROM0,
			GPD_MODE_EXT_NOROM1:
				pb_func_eff[GPD_PB_ADDR_PINS-1:0] = '1;
			GPD_MODE_EXT_ROM:
				pb_func_eff[GPD_PB_ADDR_PINS-1:0] =
					i_pb_func[GPD_PB_ADDR_PINS-1:0];
			GPD_MODE_SINGLE:
				pb_func_eff[GPD_PB_ADDR_PINS-1:0] = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// Data registers
	// ----------------------------------------------------------------
	logic [GPD_PA_UPPER_W-1:0] pah_rd;
	logic [GPD_PA_LOWER_W-1:0] pal_rd;
	logic [GPD_PB_W-1:0]       pb_rd;

	gpd_port_bits #(.W(GPD_PA_UPPER_W), .HAS_PINS(PA_UPPER_PINS)) u_pah
	(
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_wmask    (acc.pah_wmask),
		.i_wdata    (acc.pah_wdata),
		.i_pin      (i_pa_pin[GPD_PA_W-1:GPD_PA_LOWER_W]),
		.i_dir      (i_pa_dir[GPD_PA_W-1:GPD_PA_LOWER_W]),
		.i_func     (i_pa_func[GPD_PA_W-1:GPD_PA_LOWER_W]),
		.o_rd_value (pah_rd),
		.o_pin_out  (o_pa_out[GPD_PA_W-1:GPD_PA_LOWER_W]),
		.o_pin_oe   (o_pa_oe[GPD_PA_W-1:GPD_PA_LOWER_W])
	);

	gpd_port_bits #(.W(GPD_PA_LOWER_W), .HAS_PINS(1'b1)) u_pal
	(
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_wmask    (acc.pal_wmask),
		.i_wdata    (acc.pal_wdata),
		.i_pin      (i_pa_pin[GPD_PA_LOWER_W-1:0]),
		.i_dir      (i_pa_dir[GPD_PA_LOWER_W-1:0]),
		.i_func     (i_pa_func[GPD_PA_LOWER_W-1:0]),
		.o_rd_value (pal_rd),
		.o_pin_out  (o_pa_out[GPD_PA_LOWER_W-1:0]),
		.o_pin_oe   (o_pa_oe[GPD_PA_LOWER_W-1:0])
	);

	gpd_port_bits #(.W(GPD_PB_W), .HAS_PINS(1'b1)) u_pb
	(
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_wmask    (acc.pb_wmask),
		.i_wdata    (acc.pb_wdata),
		.i_pin      (i_pb_pin),
		.i_dir      (i_pb_dir),
		.i_func     (pb_func_eff),
		.o_rd_value (pb_rd),
		.o_pin_out  (o_pb_out),
		.o_pin_oe   (o_pb_oe)
	);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [31:0] rdata;
	} gpd_top_st_t;

	gpd_top_st_t st;
	gpd_top_st_t next_st;
	logic [15:0] pah_ext;
	logic [15:0] pal_ext;
	logic [15:0] pb_ext;

	function automatic logic [31:0] place(input logic [31:0] ra,
		input logic [15:0] v);
		place = ra[1] ? {16'h0000, v} : {v, 16'h0000};
	endfunction : place

	always_comb
	begin
		// Unused upper bits read as zero.
		pah_ext = {{(GPD_REG_W-GPD_PA_UPPER_W){1'b0}}, pah_rd};
		pal_ext = pal_rd;
		pb_ext  = {{(GPD_REG_W-GPD_PB_W){1'b0}}, pb_rd};
		next_st.rdata = GPD_RDATA_RESET;
		if (acc.rd_pa)
		begin
			next_st.rdata = (place(GPD_PA_UPPER_ADDR, pah_ext)
				| place(GPD_PA_LOWER_ADDR, pal_ext)) & acc.rd_lanes;
		end
		else if (acc.rd_pb)
		begin
			next_st.rdata = place(GPD_PB_ADDR, pb_ext) & acc.rd_lanes;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			st.rdata <= GPD_RDATA_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;

endmodule : gpd_top
`default_nettype wire

// >>> test/gpd_chk.sv
// Concurrent checks on the port data register block.
`timescale 1ns/10ps
`default_nettype none
module gpd_chk
(
	input  wire logic               i_mclk,
	input  wire logic               i_resetn,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	input  wire logic [31:0]        i_addr,
	input  wire logic [31:0]        i_wdata,
	input  wire logic [31:0]        o_rdata,
	input  wire gpd_pkg::gpd_size_t i_size,
	input  wire gpd_pkg::gpd_mode_t i_mode,
	input  wire logic [23:0]        i_pa_pin,
	input  wire logic [23:0]        i_pa_dir,
	input  wire logic [23:0]        i_pa_func,
	input  wire logic [23:0]        o_pa_out,
	input  wire logic [23:0]        o_pa_oe,
	input  wire logic [9:0]         i_pb_pin,
	input  wire logic [9:0]         i_pb_dir,
	input  wire logic [9:0]         i_pb_func,
	input  wire logic [9:0]         o_pb_out,
	input  wire logic [9:0]         o_pb_oe
);
	import gpd_pkg::*;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not idle");
	a_pa_oe_lag: assert property ($past(i_resetn) |->
		o_pa_oe == ($past(i_pa_dir) & ~$past(i_pa_func)))
		else $error("port A enable wrong");
	a_pb_oe_lag: assert property ($past(i_resetn) |->
		o_pb_oe[9:2] == ($past(i_pb_dir[9:2]) & ~$past(i_pb_func[9:2])))
		else $error("port B enable wrong");
	a_addr_pins: assert property ($past(i_resetn) &&
		$past(i_mode) <= GPD_MODE_EXT_NOROM1 |-> o_pb_oe[1:0] == 2'b00)
		else $error("address pins driven as port");
	a_out_hold: assert property ($past(i_resetn) && !$past(i_wr) |->
		$stable(o_pa_out) && $stable(o_pb_out))
		else $error("data changed without write");
	a_pa_write: assert property ($past(i_wr) &&
		$past(i_addr) == GPD_PA_UPPER_ADDR && $past(i_size) == GPD_SIZE_LONG
		|-> o_pa_out == {$past(i_wdata[23:16]), $past(i_wdata[15:0])})
		else $error("port A write lost");
	a_pa_read: assert property ($past(i_rd) &&
		$past(i_addr) == GPD_PA_UPPER_ADDR && $past(i_size) == GPD_SIZE_LONG
		|-> o_rdata == {8'h0, $past(i_pa_dir) & $past(o_pa_out)
		| ~$past(i_pa_dir) & $past(i_pa_pin)})
		else $error("port A read wrong");
	a_pb_read: assert property ($past(i_rd) &&
		$past(i_addr) == GPD_PB_ADDR && $past(i_size) == GPD_SIZE_WORD
		|-> o_rdata == {6'h0, $past(i_pb_dir) & $past(o_pb_out)
		| ~$past(i_pb_dir) & $past(i_pb_pin), 16'h0})
		else $error("port B read wrong");
	c_read: cover property ($past(i_rd) && o_rdata != 32'h0);
	c_write: cover property ($past(i_wr) && $changed(o_pb_out));
	c_rom_mode: cover property (i_mode == GPD_MODE_EXT_ROM && o_pb_oe[0]);
endmodule : gpd_chk
`default_nettype wire

// >>> test/port_a_b_data_registers_test.sv
// Self-checking bench for the port data register block.
`timescale 1ns/10ps
`default_nettype none
module port_a_b_data_registers_test;
	import gpd_pkg::*;
	logic        i_mclk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [31:0] i_addr = '0, i_wdata = '0, o_rdata, q;
	gpd_size_t   i_size = GPD_SIZE_WORD;
	gpd_mode_t   i_mode = GPD_MODE_SINGLE;
	logic [23:0] i_pa_pin = '0, i_pa_dir = '0, i_pa_func = '0;
	logic [23:0] o_pa_out, o_pa_oe, m_pa = '0;
	logic [9:0]  i_pb_pin = '0, i_pb_dir = '0, i_pb_func = '0;
	logic [9:0]  o_pb_out, o_pb_oe, m_pb = '0, fe;
	logic [31:0] seed = 32'h403f1dba;
	int          num_errors = 0, total_checks = 0;
	always #50 i_mclk = ~i_mclk;
	gpd_top i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_size(i_size), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_mode(i_mode), .i_pa_pin(i_pa_pin),
		.i_pa_dir(i_pa_dir), .i_pa_func(i_pa_func), .o_pa_out(o_pa_out),
		.o_pa_oe(o_pa_oe), .i_pb_pin(i_pb_pin), .i_pb_dir(i_pb_dir),
		.i_pb_func(i_pb_func), .o_pb_out(o_pb_out), .o_pb_oe(o_pb_oe));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] exp_pa();
		return {8'h0, i_pa_dir & m_pa | ~i_pa_dir & i_pa_pin};
	endfunction : exp_pa
	function automatic logic [31:0] exp_pb();
		return {6'h0, i_pb_dir & m_pb | ~i_pb_dir & i_pb_pin, 16'h0};
	endfunction : exp_pb
	task automatic check(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// The answer stands only in the cycle after the strobe edge.
	task automatic bus(input logic w, input logic [31:0] a, d,
		input gpd_size_t s);
		@(posedge i_mclk);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= d;
		i_size <= s;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		#1;
		q = o_rdata;
	endtask : bus
	task automatic rst();
		@(posedge i_mclk);
		i_resetn <= 1'b0;
		i_pa_dir <= '1;
		i_pb_dir <= '1;
		repeat (10) @(posedge i_mclk);
		i_resetn <= 1'b1;
		m_pa = '0;
		m_pb = '0;
		bus(1'b0, GPD_PA_UPPER_ADDR, '0, GPD_SIZE_LONG);
		check("pa_reset", 32'h0, q);
		bus(1'b0, GPD_PB_ADDR, '0, GPD_SIZE_LONG);
		check("pb_reset", 32'h0, q);
		$display("reset test done");
	endtask : rst
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		num_errors++;
		tally_and_finish();
	end
	initial
	begin
		rst();
		repeat (40)
		begin
			@(posedge i_mclk);
			seed = lfsr(seed);
			i_pa_dir <= seed[23:0];
			i_pb_dir <= seed[31:22];
			i_mode <= gpd_mode_t'(seed[5:4]);
			seed = lfsr(seed);
			i_pa_func <= seed[30:7];
			i_pb_func <= seed[9:0];
			seed = lfsr(seed);
			i_pa_pin <= seed[23:0];
			i_pb_pin <= seed[31:22];
			seed = lfsr(seed);
			bus(1'b1, GPD_PA_UPPER_ADDR, seed, GPD_SIZE_LONG);
			m_pa = seed[23:0];
			bus(1'b1, GPD_PB_ADDR, ~seed, GPD_SIZE_WORD);
			m_pb = ~seed[25:16];
			check("pa_out", {8'h0, m_pa}, {8'h0, o_pa_out});
			check("pb_out", {22'h0, m_pb}, {22'h0, o_pb_out});
			check("pa_oe", {8'h0, i_pa_dir & ~i_pa_func}, {8'h0, o_pa_oe});
			fe = i_pb_func;
			if (i_mode <= GPD_MODE_EXT_NOROM1)
				fe[1:0] = 2'b11;
			else if (i_mode == GPD_MODE_SINGLE)
				fe[1:0] = 2'b00;
			check("pb_oe", {22'h0, i_pb_dir & ~fe}, {22'h0, o_pb_oe});
			bus(1'b0, GPD_PA_UPPER_ADDR, '0, GPD_SIZE_LONG);
			check("pa_read", exp_pa(), q);
			bus(1'b0, GPD_PB_ADDR, '0, GPD_SIZE_WORD);
			check("pb_read", exp_pb(), q);
		end
		$display("random test done");
		@(posedge i_mclk);
		i_pb_dir <= '1;
		bus(1'b1, GPD_PB_ADDR, 32'hff000000, GPD_SIZE_BYTE);
		bus(1'b1, GPD_PB_ADDR + 1, 32'h00a50000, GPD_SIZE_BYTE);
		bus(1'b1, GPD_PB_ADDR + 2, 32'h0000ffff, GPD_SIZE_WORD);
		m_pb = 10'h3a5;
		bus(1'b0, GPD_PB_ADDR + 1, '0, GPD_SIZE_BYTE);
		check("pb_byte", 32'h00a50000, q);
		bus(1'b0, GPD_PB_ADDR, '0, GPD_SIZE_LONG);
		check("pb_long", exp_pb(), q);
		bus(1'b0, GPD_PB_ADDR + 2, '0, GPD_SIZE_WORD);
		check("unmapped", 32'h0, q);
		bus(1'b1, GPD_PB_ADDR, 32'hffffffff, GPD_SIZE_NONE);
		bus(1'b0, GPD_PB_ADDR, '0, GPD_SIZE_LONG);
		check("pb_none_wr", exp_pb(), q);
		bus(1'b0, GPD_PB_ADDR, '0, GPD_SIZE_NONE);
		check("pb_none_rd", 32'h0, q);
		@(posedge i_mclk);
		i_pa_dir <= '1;
		bus(1'b1, GPD_PA_LOWER_ADDR, 32'h00005a3c, GPD_SIZE_WORD);
		bus(1'b1, GPD_PA_UPPER_ADDR + 1, 32'h00c30000, GPD_SIZE_BYTE);
		m_pa = 24'hc35a3c;
		check("pa_bytes", {8'h0, m_pa}, {8'h0, o_pa_out});
		bus(1'b0, GPD_PA_LOWER_ADDR, '0, GPD_SIZE_WORD);
		check("pa_lower", 32'h00005a3c, q);
		bus(1'b0, GPD_PA_UPPER_ADDR, '0, GPD_SIZE_WORD);
		check("pa_upper", 32'h00c30000, q);
		$display("byte test done");
		rst();
		tally_and_finish();
	end
endmodule : port_a_b_data_registers_test
bind gpd_top gpd_chk i_chk (.i_mclk(i_mclk), .i_resetn(i_resetn),
	.i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
	.o_rdata(o_rdata), .i_size(i_size), .i_mode(i_mode),
	.i_pa_pin(i_pa_pin), .i_pa_dir(i_pa_dir), .i_pa_func(i_pa_func),
	.o_pa_out(o_pa_out), .o_pa_oe(o_pa_oe), .i_pb_pin(i_pb_pin),
	.i_pb_dir(i_pb_dir), .i_pb_func(i_pb_func), .o_pb_out(o_pb_out),
	.o_pb_oe(o_pb_oe));
`default_nettype wire
